// File: verilog/fppi_cfg.svh
// Offsets, field positions, reset values and timing counts of the FIFO port host
// How it works
// - Assert DMA acknowledge for non-multiplexed DMA
// - Separate read and write strobes, low pulses
// - Strobe only while chip select, DMA acknowledge or interrupt acknowledge held low
// - Control/data pin marks control or FIFO byte
// - Assert interrupt acknowledge for vector reads
// - Multiplexed bus carries address then data
// - DMA strobe moves bytes in multiplexed mode
// - Data strobe times multiplexed processor transfers
// - Read/write high reads, low writes
// - Pull acknowledge low when data taken/valid
// - Clear line low empties the FIFO
// - Data direction line reported as status
`ifndef FPPI_CFG_SVH
`define FPPI_CFG_SVH
`define FPPI_CLK_NS 20
`define FPPI_STB_NS 100
`define FPPI_REC_NS 60
`define FPPI_STB_CYC ((`FPPI_STB_NS + `FPPI_CLK_NS - 1) / `FPPI_CLK_NS)
`define FPPI_REC_CYC ((`FPPI_REC_NS + `FPPI_CLK_NS - 1) / `FPPI_CLK_NS)
`define FPPI_OFS_CTRL 12'h000
`define FPPI_OFS_CMD 12'h004
`define FPPI_OFS_STAT 12'h008
`define FPPI_CTRL_RST 7'h00
`define FPPI_MODE_NM 2'h0
`define FPPI_MODE_MX 2'h1
`define FPPI_MODE_HS 2'h2
`define FPPI_BIT_DMA 2
`define FPPI_BIT_CLR 3
`define FPPI_BIT_GPIN 4
`define FPPI_BIT_IEN 5
`define FPPI_CMD_ADDR 11:8
`define FPPI_CMD_CD 12
`define FPPI_CMD_RD 13
`define FPPI_CMD_IACK 14
`define FPPI_STAT_DONE 9
`endif

// File: verilog/fppi_pkg.sv
// Types shared by the FIFO port host
package fppi_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_AGAP = 3'b010,
    S_STB = 3'b011,
    S_REC = 3'b100,
    S_HWAIT = 3'b101,
    S_HACK = 3'b110
  } fppi_state_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } fppi_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } fppi_apb_rsp_t;
endpackage

// File: verilog/fppi_host.sv
// Host controller driving the FIFO port pins, steered over APB
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "fppi_cfg.svh"
module fppi_host (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // APB slave
  input wire fppi_pkg::fppi_apb_req_t apb_i,
  output fppi_pkg::fppi_apb_rsp_t apb_o,
  // Shared data bus
  input wire logic [7:0] d_i,
  output logic [7:0] d_o,
  output logic d_oe_o,
  // Processor modes
  input wire logic req_wait_n_i,
  output logic dma_ack_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic ce_n_o,
  output logic cd_o,
  output logic irq_ack_n_o,
  output logic dma_strobe_n_o,
  output logic data_strobe_n_o,
  output logic rw_o,
  output logic addr_strobe_n_o,
  output logic cs_n_o,
  // Interrupt chain
  output logic chain_enable_in_o,
  input wire logic chain_enable_out_i,
  input wire logic irq_n_i,
  // Handshake mode
  input wire logic ready_or_avail_i,
  output logic handshake_ack_n_o,
  input wire logic full_i,
  input wire logic empty_i,
  input wire logic clear_n_i,
  output logic clear_n_o,
  output logic clear_n_oe_o,
  input wire logic data_dir_i,
  output logic gp_input_bit0_o,
  input wire logic gp_output_bit1_i,
  input wire logic gp_output_bit3_i,
  output logic oe_n_o
);
  import fppi_pkg::*;

  localparam logic [3:0] STB_LAST = 4'(`FPPI_STB_CYC - 1);
  localparam logic [3:0] REC_LAST = 4'(`FPPI_REC_CYC - 1);

  typedef struct packed {
    fppi_state_t st;
    logic [3:0] cnt;
    logic [1:0] mode;
    logic dma;
    logic clr;
    logic gpin;
    logic ien;
    logic [7:0] wdata;
    logic [3:0] addr;
    logic cd;
    logic rd;
    logic iack;
    logic [7:0] rdata;
    logic done;
    logic [31:0] prdata;
    logic pslverr;
  } fppi_regs_t;

  fppi_regs_t s;
  fppi_regs_t next_s;
  logic nm;
  logic mx;
  logic hs;
  logic busy;
  logic strobing;
  logic wr_acc;
  logic peer_ok;

  function automatic logic is_map(input logic [11:0] a);
    is_map = (a == `FPPI_OFS_CTRL) || (a == `FPPI_OFS_CMD) || (a == `FPPI_OFS_STAT);
  endfunction

  assign nm = s.mode == `FPPI_MODE_NM;
  assign mx = s.mode == `FPPI_MODE_MX;
  assign hs = s.mode == `FPPI_MODE_HS;
  assign busy = s.st != S_IDLE;
  assign strobing = s.st == S_STB;
  assign wr_acc = apb_i.psel && apb_i.penable && apb_i.pwrite;
  // Interlock: device must answer before the acknowledge is released
  assign peer_ok = s.rd ? ready_or_avail_i : !ready_or_avail_i;

  always_comb begin
    next_s = s;
    if (apb_i.psel && !apb_i.penable) begin
      next_s.pslverr = !is_map(apb_i.paddr);
      unique case (apb_i.paddr)
        `FPPI_OFS_CTRL: next_s.prdata = {26'h0000000, s.ien, s.gpin, s.clr, s.dma, s.mode};
        `FPPI_OFS_STAT: next_s.prdata = {12'h000, !req_wait_n_i, gp_output_bit3_i,
          gp_output_bit1_i, clear_n_i, data_dir_i, ready_or_avail_i, empty_i, full_i,
          chain_enable_out_i, !irq_n_i, s.done, busy, s.rdata};
        default: next_s.prdata = 32'h00000000;
      endcase
      // A new command while busy is refused and flagged
      if (apb_i.pwrite && apb_i.paddr == `FPPI_OFS_CMD && busy) begin
        next_s.pslverr = 1'b1;
      end
    end
    if (wr_acc && apb_i.paddr == `FPPI_OFS_CTRL) begin
      next_s.mode = apb_i.pwdata[1:0];
      next_s.dma = apb_i.pwdata[`FPPI_BIT_DMA];
      next_s.clr = apb_i.pwdata[`FPPI_BIT_CLR];
      next_s.gpin = apb_i.pwdata[`FPPI_BIT_GPIN];
      next_s.ien = apb_i.pwdata[`FPPI_BIT_IEN];
    end
    if (wr_acc && apb_i.paddr == `FPPI_OFS_STAT && apb_i.pwdata[`FPPI_STAT_DONE]) begin
      next_s.done = 1'b0;
    end
    if (wr_acc && apb_i.paddr == `FPPI_OFS_CMD && !busy) begin
      next_s.wdata = apb_i.pwdata[7:0];
      next_s.addr = apb_i.pwdata[`FPPI_CMD_ADDR];
      next_s.cd = apb_i.pwdata[`FPPI_CMD_CD];
      next_s.rd = apb_i.pwdata[`FPPI_CMD_RD] || apb_i.pwdata[`FPPI_CMD_IACK];
      next_s.iack = apb_i.pwdata[`FPPI_CMD_IACK];
      next_s.cnt = STB_LAST;
      if (hs) begin
        next_s.st = S_HWAIT;
      end else if (mx && !s.dma) begin
        next_s.st = S_ADDR;
      end else begin
        next_s.st = S_STB;
      end
    end
    unique case (s.st)
      S_IDLE: begin
      end
      S_ADDR: begin
        if (s.cnt != 4'h0) begin
          next_s.cnt = s.cnt - 4'h1;
        end else begin
          next_s.st = S_AGAP;
        end
      end
      S_AGAP: begin
        next_s.st = S_STB;
        next_s.cnt = STB_LAST;
      end
      S_STB: begin
        if (s.cnt != 4'h0) begin
          next_s.cnt = s.cnt - 4'h1;
        end else if (s.dma || req_wait_n_i) begin
          if (s.rd) begin
            next_s.rdata = d_i;
          end
          next_s.st = S_REC;
          next_s.cnt = REC_LAST;
        end
      end
      S_REC: begin
        if (s.cnt != 4'h0) begin
          next_s.cnt = s.cnt - 4'h1;
        end else begin
          next_s.st = S_IDLE;
          next_s.done = 1'b1;
        end
      end
      S_HWAIT: begin
        if (!peer_ok) begin
          next_s.st = S_HACK;
          next_s.cnt = STB_LAST;
        end
      end
      S_HACK: begin
        if (s.cnt != 4'h0) begin
          next_s.cnt = s.cnt - 4'h1;
          if (s.rd && s.cnt == 4'h1) begin
            next_s.rdata = d_i;
          end
        end else if (peer_ok) begin
          next_s.st = S_REC;
          next_s.cnt = REC_LAST;
        end
      end
      default: next_s.st = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign apb_o.prdata = s.prdata;
  assign apb_o.pready = apb_i.psel && apb_i.penable;
  assign apb_o.pslverr = apb_i.psel && apb_i.penable && s.pslverr;

  // Pin decode; all strobes idle high outside a transfer
  always_comb begin
    rd_n_o = !(nm && strobing && s.rd);
    wr_n_o = !(nm && strobing && !s.rd);
    ce_n_o = !(nm && !s.dma && !s.iack && (strobing || s.st == S_REC));
    dma_ack_n_o = !(nm && s.dma && (strobing || s.st == S_REC));
    irq_ack_n_o = !(s.iack && (nm ? (strobing || s.st == S_REC)
      : (s.st == S_ADDR || s.st == S_AGAP)));
    addr_strobe_n_o = !(mx && s.st == S_ADDR);
    cs_n_o = !(mx && !s.iack && (s.st == S_ADDR || s.st == S_AGAP));
    data_strobe_n_o = !(mx && !s.dma && strobing);
    dma_strobe_n_o = !(mx && s.dma && strobing);
    rw_o = busy ? s.rd : 1'b1;
    cd_o = s.cd;
    d_o = (s.st == S_ADDR) ? {4'h0, s.addr} : s.wdata;
    d_oe_o = (mx && s.st == S_ADDR) || (!s.rd && (((nm || mx) &&
      (strobing || s.st == S_REC)) || (hs && (s.st == S_HWAIT || s.st == S_HACK))));
    oe_n_o = !(hs && s.rd && s.st == S_HACK);
    handshake_ack_n_o = !(hs && s.st == S_HACK);
    chain_enable_in_o = s.ien;
    gp_input_bit0_o = s.gpin;
    clear_n_o = 1'b0;
    clear_n_oe_o = s.clr;
  end

  localparam int STBC = `FPPI_STB_CYC;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence seq_addr_phase;
    !addr_strobe_n_o && !cs_n_o;
  endsequence
  sequence seq_data_phase;
    addr_strobe_n_o && !data_strobe_n_o;
  endsequence
  // Interlock acknowledge is held as long as a processor strobe
  sequence seq_ack_width;
    !handshake_ack_n_o [*5];
  endsequence

  a_strobe_sel: assert property (
    (!rd_n_o || !wr_n_o) |-> (!ce_n_o || !dma_ack_n_o || !irq_ack_n_o))
    else $error("Strobe without select");
  a_rd_wr_excl: assert property (
    !(!rd_n_o && !wr_n_o))
    else $error("Read and write strobes together");
  a_strobe_width: assert property (
    $fell(rd_n_o) |-> !rd_n_o [*5])
    else $error("Read strobe too short");
  a_write_width: assert property (
    $fell(wr_n_o) |-> !wr_n_o [*5])
    else $error("Write strobe too short");
  a_mux_cycle: assert property (
    $fell(addr_strobe_n_o) && !s.iack |->
    seq_addr_phase ##[1:STBC] (addr_strobe_n_o && !cs_n_o) ##1 seq_data_phase)
    else $error("Multiplexed cycle out of order");
  a_mux_iack: assert property (
    $fell(addr_strobe_n_o) && s.iack |-> !irq_ack_n_o && cs_n_o)
    else $error("Vector cycle without acknowledge");
  a_mux_addr: assert property (
    !addr_strobe_n_o |-> d_oe_o && d_o == {4'h0, s.addr})
    else $error("Address not on bus");
  a_ds_width: assert property (
    $fell(data_strobe_n_o) |-> !data_strobe_n_o [*5])
    else $error("Data strobe too short");
  a_rw_stable: assert property (
    !data_strobe_n_o |-> rw_o == s.rd && $stable(rw_o))
    else $error("Read/write moved under strobe");
  a_cd_stable: assert property (
    (!rd_n_o || !wr_n_o) && $past(!rd_n_o || !wr_n_o) |-> $stable(cd_o))
    else $error("Control/data moved under strobe");
  a_dma_strobe: assert property (
    !dma_strobe_n_o |-> cs_n_o && addr_strobe_n_o && mx)
    else $error("DMA strobe with processor cycle");
  a_dma_width: assert property (
    $fell(dma_strobe_n_o) |-> !dma_strobe_n_o [*5])
    else $error("DMA strobe too short");
  a_iack_sel: assert property (
    !irq_ack_n_o |-> ce_n_o && cs_n_o)
    else $error("Acknowledge with chip select");
  a_dma_ack_n_mode: assert property (
    !dma_ack_n_o |-> s.dma && nm)
    else $error("DMA acknowledge outside DMA");
  a_hs_ack: assert property (
    $fell(handshake_ack_n_o) |-> (s.rd ? !$past(ready_or_avail_i) : $past(ready_or_avail_i)))
    else $error("Acknowledge before device ready");
  a_hs_width: assert property (
    $fell(handshake_ack_n_o) |-> seq_ack_width)
    else $error("Handshake acknowledge too short");
  a_bus_fight: assert property (
    !(d_oe_o && !oe_n_o))
    else $error("Both ends drive the bus");
  a_clear_drv: assert property (
    wr_acc && apb_i.paddr == `FPPI_OFS_CTRL |=>
    clear_n_oe_o == $past(apb_i.pwdata[`FPPI_BIT_CLR]))
    else $error("Clear drive not updated");
  a_clear_pin: assert property (
    clear_n_oe_o |-> !clear_n_o)
    else $error("Clear driven high");
  a_wait_hold: assert property (
    strobing && s.cnt == 4'h0 && !s.dma && !req_wait_n_i |=> strobing)
    else $error("Wait ignored");
endmodule // fppi_host

// File: tb/fppi_dev_model.sv
// Behavioural FIFO port device answering the host's pins
`timescale 1ns/10ps
module fppi_dev_model #(
  parameter logic [7:0] RD_BYTE = 8'h96
) (
  // Bench control
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] stall_i,
  input wire logic irq_req_i,
  // Host pins
  input wire logic [7:0] bus_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic ce_n_i,
  input wire logic dma_ack_n_i,
  input wire logic irq_ack_n_i,
  input wire logic cd_i,
  input wire logic addr_strobe_n_i,
  input wire logic cs_n_i,
  input wire logic data_strobe_n_i,
  input wire logic dma_strobe_n_i,
  input wire logic rw_i,
  input wire logic handshake_ack_n_i,
  input wire logic oe_n_i,
  input wire logic chain_enable_in_i,
  input wire logic clear_n_i,
  input wire logic gp_input_bit0_i,
  // Device pins
  output logic [7:0] dev_d_o,
  output logic dev_oe_o,
  output logic req_wait_n_o,
  output logic irq_n_o,
  output logic chain_enable_out_o,
  output logic ready_or_avail_o,
  output logic empty_o,
  output logic gp_output_bit1_o,
  // Captured for the bench
  output logic [7:0] got_byte_o,
  output logic got_cd_o,
  output logic [3:0] got_addr_o
);
  logic as_q;
  logic cs_lat;
  logic [3:0] cnt;
  logic strobe;
  assign strobe = !rd_n_i || !wr_n_i || !data_strobe_n_i || !handshake_ack_n_i;
  // Slow answers: the wait line holds for stall_i cycles of each strobe except the DMA strobe
  assign req_wait_n_o = !(strobe && cnt < stall_i);
  assign dev_oe_o = (!rd_n_i && !(ce_n_i && irq_ack_n_i && dma_ack_n_i))
    || (!data_strobe_n_i && rw_i && cs_lat) || (!dma_strobe_n_i && rw_i)
    || !oe_n_i;
  assign dev_d_o = RD_BYTE;
  assign irq_n_o = !irq_req_i;
  assign chain_enable_out_o = chain_enable_in_i && !irq_req_i;
  assign gp_output_bit1_o = gp_input_bit0_i;
  // Pins are sampled on the clock so host decode glitches cannot fake an edge
  always @(posedge clk_i) begin
    as_q <= addr_strobe_n_i;
    cnt <= strobe ? cnt + 4'h1 : 4'h0;
    if (!nrst_i) begin
      cs_lat <= 1'b0;
      ready_or_avail_o <= 1'b0;
      empty_o <= 1'b0;
      got_byte_o <= 8'h00;
      got_cd_o <= 1'b0;
      got_addr_o <= 4'h0;
    end else begin
      if (!wr_n_i && !(ce_n_i && dma_ack_n_i)) begin
        got_byte_o <= bus_i;
        got_cd_o <= cd_i;
      end
      if (!addr_strobe_n_i) got_addr_o <= bus_i[3:0];
      if (!as_q && addr_strobe_n_i) cs_lat <= !cs_n_i || !irq_ack_n_i;
      if (!data_strobe_n_i && !rw_i && cs_lat) got_byte_o <= bus_i;
      if (!dma_strobe_n_i && !rw_i) got_byte_o <= bus_i;
      if (!handshake_ack_n_i && oe_n_i) got_byte_o <= bus_i;
      // Each acknowledge flips the line, answering the interlock
      if (!handshake_ack_n_i && cnt == 4'h5) ready_or_avail_o <= !ready_or_avail_o;
      if (!clear_n_i) empty_o <= 1'b1;
    end
  end
endmodule // fppi_dev_model

// File: tb/test_fppi_host.sv
// Self-checking bench for the FIFO port host
`timescale 1ns/10ps
`include "fppi_cfg.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module test_fppi_host;
  import fppi_pkg::*;
  localparam logic [7:0] RDB = 8'h96;
  int err_count = 0;
  int cmp_count = 0;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] stall = 4'h0;
  logic irq_req = 1'b0;
  logic [2:0] pins = 3'h0;
  fppi_apb_req_t req = '0;
  fppi_apb_rsp_t rsp;
  logic [7:0] d_o, d_i, dev_d, got_byte;
  logic [3:0] got_addr;
  logic d_oe, dev_oe, dma_ack_n_n, rd_n, wr_n, ce_n, cd, iack_n, dstb_n, ds_n, rw, as_n, cs_n;
  logic cin, cout, irq_n, rdy, hack_n, clr_o, clr_oe, clr_n, gp0, gp1, oe_n, wait_n, empty;
  logic got_cd;
  logic [31:0] st;
  logic e;
  // Undriven bus and clear line rest high on their pull-ups
  assign d_i = d_oe ? d_o : (dev_oe ? dev_d : 8'hFF);
  assign clr_n = clr_oe ? clr_o : 1'b1;
  fppi_host fppi_host_inst (.ref_clk_i(clk), .nrst_i(nrst), .apb_i(req), .apb_o(rsp),
    .d_i(d_i), .d_o(d_o), .d_oe_o(d_oe), .req_wait_n_i(wait_n), .dma_ack_n_o(dma_ack_n_n),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .ce_n_o(ce_n), .cd_o(cd), .irq_ack_n_o(iack_n),
    .dma_strobe_n_o(dstb_n), .data_strobe_n_o(ds_n), .rw_o(rw), .addr_strobe_n_o(as_n),
    .cs_n_o(cs_n), .chain_enable_in_o(cin), .chain_enable_out_i(cout), .irq_n_i(irq_n),
    .ready_or_avail_i(rdy), .handshake_ack_n_o(hack_n), .full_i(pins[0]), .empty_i(empty),
    .clear_n_i(clr_n), .clear_n_o(clr_o), .clear_n_oe_o(clr_oe), .data_dir_i(pins[1]),
    .gp_input_bit0_o(gp0), .gp_output_bit1_i(gp1), .gp_output_bit3_i(pins[2]), .oe_n_o(oe_n));
  fppi_dev_model #(.RD_BYTE(RDB)) fppi_dev_model_inst (.clk_i(clk), .nrst_i(nrst),
    .stall_i(stall), .irq_req_i(irq_req), .bus_i(d_i), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .ce_n_i(ce_n), .dma_ack_n_i(dma_ack_n_n), .irq_ack_n_i(iack_n), .cd_i(cd),
    .addr_strobe_n_i(as_n), .cs_n_i(cs_n), .data_strobe_n_i(ds_n), .rw_i(rw),
    .dma_strobe_n_i(dstb_n),
    .handshake_ack_n_i(hack_n), .oe_n_i(oe_n), .chain_enable_in_i(cin), .clear_n_i(clr_n),
    .gp_input_bit0_i(gp0), .dev_d_o(dev_d), .dev_oe_o(dev_oe), .req_wait_n_o(wait_n),
    .irq_n_o(irq_n), .chain_enable_out_o(cout), .ready_or_avail_o(rdy), .empty_o(empty),
    .gp_output_bit1_o(gp1), .got_byte_o(got_byte), .got_cd_o(got_cd), .got_addr_o(got_addr));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic hang(input int n);
    if (n > 100) begin
      err_count++;
      $display("Error at %0t: wait ran out", $time);
      report_and_stop();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, wd};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (rsp.pready !== 1'b1) begin
      n++;
      hang(n);
      @(posedge clk);
    end
    st = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  // Issue one device transfer and wait for its completion flag
  task automatic cmd(input logic [31:0] c);
    int n;
    n = 0;
    apb(1'b1, `FPPI_OFS_CMD, c);
    st = '0;
    while (st[`FPPI_STAT_DONE] !== 1'b1) begin
      n++;
      hang(n);
      apb(1'b0, `FPPI_OFS_STAT, '0);
    end
    apb(1'b1, `FPPI_OFS_STAT, 32'h0000_0200);
  endtask
  task automatic t_reset();
    apb(1'b0, `FPPI_OFS_CTRL, '0);
    `CHK(st, {25'h0, `FPPI_CTRL_RST})
    `CHK({rw, d_oe, oe_n, wr_n, rd_n, clr_oe}, 6'h2E)
    apb(1'b0, 12'h00C, '0);
    `CHK({e, st}, 33'h1_0000_0000)
  endtask
  task automatic t_nonmux();
    apb(1'b1, `FPPI_OFS_CTRL, 32'h0);
    stall <= 4'h8;
    cmd(32'h0000_103C);
    `CHK({got_cd, got_byte}, 9'h13C)
    stall <= 4'h0;
    cmd(32'h0000_6000);
    `CHK(st[7:0], RDB)
    apb(1'b1, `FPPI_OFS_CTRL, 32'h4);
    cmd(32'h0000_0071);
    `CHK({got_cd, got_byte}, 9'h071)
  endtask
  task automatic t_mux();
    apb(1'b1, `FPPI_OFS_CTRL, 32'h1);
    cmd(32'h0000_095A);
    `CHK({got_addr, got_byte}, 12'h95A)
    cmd(32'h0000_2200);
    `CHK(st[7:0], RDB)
    cmd(32'h0000_4000);
    `CHK({got_addr, st[7:0]}, 12'h096)
    apb(1'b1, `FPPI_OFS_CTRL, 32'h5);
    cmd(32'h0000_0033);
    `CHK({got_addr, got_byte}, 12'h033)
  endtask
  task automatic t_hshake();
    apb(1'b1, `FPPI_OFS_CTRL, 32'h32);
    cmd(32'h0000_2000);
    `CHK(st[7:0], RDB)
    irq_req <= 1'b1;
    pins <= 3'h7;
    apb(1'b0, `FPPI_OFS_STAT, '0);
    `CHK({st[19:17], st[15:14], st[12:10]}, 8'h7D)
    cmd(32'h0000_00A5);
    `CHK(got_byte, 8'hA5)
    apb(1'b1, `FPPI_OFS_CTRL, 32'h3A);
    apb(1'b0, `FPPI_OFS_CTRL, '0);
    `CHK(st, 32'h0000_003A)
    apb(1'b0, `FPPI_OFS_STAT, '0);
    `CHK({clr_n, st[16], st[13]}, 3'b001)
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_nonmux();
    t_mux();
    t_hshake();
    report_and_stop();
  end
endmodule // test_fppi_host
